// ===== hdl/sector_protection_config.sv
// Purpose: Sector protection configuration with dynamic and persistent locks
// Assumes: Zero-wait AHB-Lite slave; access requests come from hclk logic
// Notes:   power_on_n models a power cycle; hresetn leaves nonvolatile state alone
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
module sector_protection_config import spc_pkg::*; #(
   parameter int          NUM_SECTORS = 8,
   parameter logic [31:0] PASSWORD    = 32'h1234_5678  // Arbitrary value
) (
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   input  wire logic                   power_on_n,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   input  wire logic                   top_bottom_select,
   input  wire logic                   access_valid,
   input  wire logic [1:0]             access_op,
   input  wire logic [$clog2(NUM_SECTORS)-1:0] access_sector,
   output logic                        access_allow,
   output logic                        access_done
);
   localparam int SW = $clog2(NUM_SECTORS);

   // Lock masks are cut from one 32-bit data word, so at most 32 sectors
   if (NUM_SECTORS < 2 || NUM_SECTORS > 32) begin : g_bad_sectors
      $error("NUM_SECTORS must lie in 2..32");
   end

   // Nonvolatile part: only a power cycle restores factory values
   typedef struct packed {
      logic [15:0]            cfg;
      logic [NUM_SECTORS-1:0] persistent_sector_lock_bit;
   } nv_s;

   // Volatile part, cleared by the bus reset
   typedef struct packed {
      logic                   load_pend;
      logic                   unlocked;
      logic                   refused;
      logic                   dp_valid;
      logic                   dp_write;
      logic [7:0]             dp_ofs;
      logic [NUM_SECTORS-1:0] dynamic_sector_lock_bit;
      logic [31:0]            rdata;
      logic                   allow;
      logic                   done;
   } vol_s;

   nv_s  nv_ff;
   nv_s  nxt_nv;
   vol_s v_ff;
   vol_s nxt_v;
   logic pwd_locked;
   logic rd_blocked;
   logic gate_allow;
   logic ap_take;
   logic dp_wr;

   assign pwd_locked = !nv_ff.cfg[BIT_PWD_MODE] && !v_ff.unlocked;
   assign rd_blocked = pwd_locked && !nv_ff.cfg[BIT_READ_PWD];
   assign ap_take    = hsel && hready && htrans[1];
   assign dp_wr      = v_ff.dp_valid && v_ff.dp_write;

   access_gate #(
      .NUM_SECTORS (NUM_SECTORS),
      .SW          (SW)
   ) u_gate (
      .cfg               (nv_ff.cfg),
      .unlocked          (v_ff.unlocked),
      .dynamic_sector_lock_bit               (v_ff.dynamic_sector_lock_bit),
      .persistent_sector_lock_bit               (nv_ff.persistent_sector_lock_bit),
      .top_bottom_select (top_bottom_select),
      .op                (access_op),
      .sector            (access_sector),
      .allow             (gate_allow)
   );

   // Next state: reset load, write data phase, read capture, access verdict
   always_comb begin
      nxt_nv      = nv_ff;
      nxt_v       = v_ff;
      nxt_v.done  = 1'b0;
      // Dynamic locks take their power-up state at the first edge after reset
      if (v_ff.load_pend) begin
         nxt_v.load_pend = 1'b0;
         nxt_v.dynamic_sector_lock_bit       = nv_ff.cfg[BIT_DYN_PWRUP] ? '0 : '1;
      end
      // Data phase of a write; writes to unmapped offsets fall through
      if (dp_wr) begin
         case (v_ff.dp_ofs)
            OFS_CFG: begin
               if (pwd_locked) begin
                  nxt_v.refused = 1'b1;
               end else begin
                  nxt_nv.cfg = hwdata[15:0] | CFG_RSVD_MASK;
               end
            end
            OFS_KEY: begin
               if (hwdata == PASSWORD) begin
                  nxt_v.unlocked = 1'b1;
               end else begin
                  nxt_v.refused = 1'b1;
               end
            end
            OFS_DYN_CLR: begin
               nxt_v.dynamic_sector_lock_bit = v_ff.dynamic_sector_lock_bit & ~hwdata[NUM_SECTORS-1:0];
            end
            OFS_DYN_SET: begin
               nxt_v.dynamic_sector_lock_bit = v_ff.dynamic_sector_lock_bit | hwdata[NUM_SECTORS-1:0];
            end
            OFS_PERS_PROG: begin
               if (pwd_locked) begin
                  nxt_v.refused = 1'b1;
               end else begin
                  nxt_nv.persistent_sector_lock_bit = nv_ff.persistent_sector_lock_bit | hwdata[NUM_SECTORS-1:0];
               end
            end
            OFS_PERS_ERASE: begin
               if (pwd_locked || !nv_ff.cfg[BIT_PERS_OTP]) begin
                  nxt_v.refused = 1'b1;
               end else begin
                  nxt_nv.persistent_sector_lock_bit = '0;
               end
            end
            OFS_STATUS: begin
               if (hwdata[ST_REFUSED]) begin
                  nxt_v.refused = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      // Address phase; read data uses post-write values so back-to-back reads are fresh
      nxt_v.dp_valid = ap_take;
      nxt_v.dp_write = hwrite;
      nxt_v.dp_ofs   = (haddr[31:8] == '0) ? haddr[7:0] : 8'hff;
      if (ap_take && !hwrite) begin
         case (nxt_v.dp_ofs)
            OFS_CFG:       nxt_v.rdata = {16'h0000, nxt_nv.cfg};
            OFS_DYN_CLR,
            OFS_DYN_SET:   nxt_v.rdata = 32'(nxt_v.dynamic_sector_lock_bit);
            OFS_PERS_PROG: nxt_v.rdata = 32'(nxt_nv.persistent_sector_lock_bit);
            // Lock flags from next state too, so a read right after a config or key write is fresh
            OFS_STATUS:    nxt_v.rdata = {28'h0000000,
                                          !nxt_nv.cfg[BIT_READ_PWD] && !nxt_nv.cfg[BIT_PWD_MODE] && !nxt_v.unlocked,
                                          !nxt_nv.cfg[BIT_PWD_MODE] && !nxt_v.unlocked,
                                          nxt_v.refused,
                                          nxt_v.unlocked};
            default:       nxt_v.rdata = 32'h0000_0000;
         endcase
      end
      // One verdict per request, one cycle later
      if (access_valid) begin
         nxt_v.allow = gate_allow;
         nxt_v.done  = 1'b1;
      end
   end

   // Nonvolatile store survives the bus reset
   always_ff @(posedge hclk or negedge power_on_n) begin
      if (!power_on_n) begin
         nv_ff <= '{cfg: CFG_FACTORY, persistent_sector_lock_bit: '0};
      end else begin
         nv_ff <= nxt_nv;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         v_ff <= '{load_pend: 1'b1, unlocked: 1'b0, refused: 1'b0, dp_valid: 1'b0, dp_write: 1'b0,
                   dp_ofs: 8'h00, dynamic_sector_lock_bit: '0, rdata: 32'h0000_0000, allow: 1'b0, done: 1'b0};
      end else begin
         v_ff <= nxt_v;
      end
   end

   // Zero-wait slave, always OKAY
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign hrdata       = v_ff.rdata;
   assign access_allow = v_ff.allow;
   assign access_done  = v_ff.done;

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn || !power_on_n);

   sequence s_wr(logic [7:0] ofs);
      dp_wr && v_ff.dp_ofs == ofs;
   endsequence

   a_rsvd_ones: assert property (nv_ff.cfg[15:6] == 10'h3ff)
      else $error("reserved config bits not all ones");
   a_rdp_off_reads: assert property (access_valid && nv_ff.cfg[BIT_READ_PWD] && access_op == OP_READ
      |=> access_done && access_allow)
      else $error("read refused with read-password mode off");
   a_rdp_blocks: assert property (access_valid && rd_blocked && access_op != OP_READ
      |=> access_done && !access_allow)
      else $error("write-type access passed under read-password lock");
   a_edge_read: assert property (access_valid && rd_blocked && access_op == OP_READ
      && access_sector == (top_bottom_select ? SW'(0) : SW'(NUM_SECTORS - 1)) |=> access_allow)
      else $error("chosen edge sector not readable");
   a_dyb_powerup: assert property (v_ff.load_pend
      |=> v_ff.dynamic_sector_lock_bit == ($past(nv_ff.cfg[BIT_DYN_PWRUP]) ? '0 : '1))
      else $error("dynamic locks wrong after reset");
   a_dyn_clear: assert property (s_wr(OFS_DYN_CLR) && !v_ff.load_pend
      |=> (v_ff.dynamic_sector_lock_bit & $past(hwdata[NUM_SECTORS-1:0])) == '0 && (v_ff.dynamic_sector_lock_bit & ~$past(v_ff.dynamic_sector_lock_bit)) == '0)
      else $error("dynamic lock clear misbehaved");
   a_otp_erase: assert property (s_wr(OFS_PERS_ERASE) && !pwd_locked && nv_ff.persistent_sector_lock_bit != '0
      |=> (nv_ff.persistent_sector_lock_bit == '0) == $past(nv_ff.cfg[BIT_PERS_OTP]))
      else $error("erase outcome does not follow one-time select");
   a_erase_refused: assert property (s_wr(OFS_PERS_ERASE) && !nv_ff.cfg[BIT_PERS_OTP]
      |=> $stable(nv_ff.persistent_sector_lock_bit) ##1 v_ff.refused)
      else $error("erase not refused while one-time");
   a_ppb_pwd_lock: assert property (s_wr(OFS_PERS_PROG) && pwd_locked
      |=> $stable(nv_ff.persistent_sector_lock_bit) && v_ff.refused)
      else $error("persistent locks changed while password locked");
   a_cfg_hold: assert property (!s_wr(OFS_CFG) |=> $stable(nv_ff.cfg))
      else $error("config changed without a write");
endmodule

// ===== hdl/spc_pkg.sv
// Purpose: Shared constants for the sector protection configuration block
// Assumes: AHB-Lite register slave, 32-bit data, one word per register
// Notes:   Register offsets, config and status field positions and access operations are listed below
package spc_pkg;
   // Register byte offsets
   localparam logic [7:0]  OFS_CFG       = 8'h00;
   localparam logic [7:0]  OFS_KEY       = 8'h04;
   localparam logic [7:0]  OFS_DYN_CLR   = 8'h08;
   localparam logic [7:0]  OFS_DYN_SET   = 8'h0c;
   localparam logic [7:0]  OFS_PERS_PROG = 8'h10;
   localparam logic [7:0]  OFS_PERS_ERASE = 8'h14;
   localparam logic [7:0]  OFS_STATUS    = 8'h18;
   localparam int          MAP_TOP       = 8'h1c;
   // Config field positions
   localparam int          BIT_READ_PWD  = 5;
   localparam int          BIT_DYN_PWRUP = 4;
   localparam int          BIT_PERS_OTP  = 3;
   localparam int          BIT_PWD_MODE  = 2;
   localparam logic [15:0] CFG_RSVD_MASK = 16'hffc0;
   localparam logic [15:0] CFG_FACTORY   = 16'hffff;
   // Status field positions
   localparam int          ST_UNLOCKED   = 0;
   localparam int          ST_REFUSED    = 1;
   localparam int          ST_PWD_LOCKED = 2;
   localparam int          ST_RD_BLOCKED = 3;
   // Sector access operations
   typedef enum logic [1:0] {
      OP_READ    = 2'b00,
      OP_PROGRAM = 2'b01,
      OP_ERASE   = 2'b10,
      OP_NONE    = 2'b11
   } access_op_e;
endpackage

// ===== hdl/access_gate.sv
// Purpose: Decide whether one sector access may proceed
// Assumes: All inputs come from flops on hclk
// Notes:   Purely combinational; the caller registers the verdict
module access_gate import spc_pkg::*; #(
   parameter int NUM_SECTORS = 8,
   parameter int SW          = 3
) (
   input  wire logic [15:0]            cfg,
   input  wire logic                   unlocked,
   input  wire logic [NUM_SECTORS-1:0] dynamic_sector_lock_bit,
   input  wire logic [NUM_SECTORS-1:0] persistent_sector_lock_bit,
   input  wire logic                   top_bottom_select,
   input  wire logic [1:0]             op,
   input  wire logic [SW-1:0]          sector,
   output logic                        allow
);
   logic          rd_block;
   logic [SW-1:0] open_sector;

   // The sector index must address every sector and nothing more
   if (SW != $clog2(NUM_SECTORS)) begin : g_bad_width
      $error("SW must equal the sector index width");
   end

   // Read-password lock needs password mode too and lapses once unlocked
   assign rd_block    = !cfg[BIT_READ_PWD] && !cfg[BIT_PWD_MODE] && !unlocked;
   // Zero picks the top sector, one the bottom
   assign open_sector = top_bottom_select ? '0 : SW'(NUM_SECTORS - 1);

   always_comb begin
      allow = 1'b0;
      if (rd_block) begin
         allow = (op == OP_READ) && (sector == open_sector);
      end else if (op == OP_READ) begin
         allow = 1'b1;
      end else if (op == OP_PROGRAM || op == OP_ERASE) begin
         allow = !dynamic_sector_lock_bit[sector] && !persistent_sector_lock_bit[sector];
      end
   end
endmodule

// ===== dv/flash_host.sv
// Purpose: Host flash controller model on the AHB-Lite register port
// Assumes: One slave; hready comes back from its hreadyout
// Notes:   Released write data shows its inverse so a stale word never passes
module flash_host import spc_pkg::*; (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus from time zero
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
   end
   // One word transfer; no latency is assumed, hready paces both phases
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      hsize  <= 3'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
      hwdata <= ~d;
   endtask
   // Upper config bits always go out as ones
   task automatic cfg_wr(input logic [5:0] low);
      logic [31:0] q;
      xfer(1'b1, OFS_CFG, {16'h0, 10'h3ff, low}, q);
   endtask
   // Dynamic locks are released one sector per write
   task automatic dyn_clr(input logic [2:0] s);
      logic [31:0] q;
      xfer(1'b1, OFS_DYN_CLR, 32'h1 << s, q);
   endtask
endmodule

// ===== dv/tb.sv
// Purpose: Self-checking bench for the sector protection configuration block
// Assumes: Zero-wait slave; access verdict one cycle after the request
// Notes:   Scenarios build on each other because config writes lock out later ones
module tb import spc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] PWD = 32'h0bad_cafe;  // Arbitrary value
   logic        hclk, hresetn, power_on_n, hsel, hwrite, hreadyout, hresp, tbs;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans, access_op;
   logic [2:0]  hsize, access_sector;
   logic        access_valid, access_allow, access_done;
   int          mismatches, n_checks, cycles;
   sector_protection_config #(.NUM_SECTORS(8), .PASSWORD(PWD)) i_sector_protection_config (
      .hclk(hclk), .hresetn(hresetn), .power_on_n(power_on_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .top_bottom_select(tbs),
      .access_valid(access_valid), .access_op(access_op), .access_sector(access_sector),
      .access_allow(access_allow), .access_done(access_done));
   flash_host i_flash_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // Hang guard; the whole run needs well under a thousand cycles
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      i_flash_host.xfer(1'b0, a, 32'h0, q);
      chk(nm, e, q);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_flash_host.xfer(1'b1, a, d, q);
   endtask
   // One access request; verdict is looked at in the cycle done stands
   task automatic acc(input access_op_e op, input logic [2:0] s, input logic e);
      @(posedge hclk);
      access_valid  <= 1'b1;
      access_op     <= op;
      access_sector <= s;
      @(posedge hclk);
      access_valid <= 1'b0;
      #1;
      chk("access_done", 32'h1, {31'h0, access_done});
      chk("access_allow", {31'h0, e}, {31'h0, access_allow});
      // Done stands one cycle; the verdict holds until the next request
      @(posedge hclk);
      #1;
      chk("access_done", 32'h0, {31'h0, access_done});
      chk("access_allow", {31'h0, e}, {31'h0, access_allow});
   endtask
   task automatic t_reset();
      rd(OFS_CFG, 32'hffff, "cfg");
      rd(OFS_DYN_CLR, 32'h0, "dyn");
      acc(OP_PROGRAM, 3'd2, 1'b1);
      acc(OP_NONE, 3'd2, 1'b0);
      rd(8'h40, 32'h0, "unmapped");
   endtask
   task automatic t_dyn();
      i_flash_host.cfg_wr(6'h2f);
      wr(OFS_PERS_PROG, 32'h1);
      wr(OFS_PERS_ERASE, 32'h1);
      rd(OFS_PERS_PROG, 32'h0, "pers");
      @(posedge hclk) hresetn <= 1'b0;
      @(posedge hclk) hresetn <= 1'b1;
      rd(OFS_CFG, 32'hffef, "cfg");
      rd(OFS_DYN_SET, 32'hff, "dyn");
      i_flash_host.dyn_clr(3'd3);
      rd(OFS_DYN_CLR, 32'hf7, "dyn");
      acc(OP_PROGRAM, 3'd3, 1'b1);
      wr(OFS_DYN_SET, 32'h8);
      rd(OFS_DYN_CLR, 32'hff, "dyn");
      acc(OP_PROGRAM, 3'd3, 1'b0);
      acc(OP_ERASE, 3'd2, 1'b0);
      acc(OP_READ, 3'd2, 1'b1);
   endtask
   task automatic t_otp();
      i_flash_host.cfg_wr(6'h27);
      i_flash_host.dyn_clr(3'd1);
      wr(OFS_PERS_PROG, 32'h2);
      wr(OFS_PERS_ERASE, 32'h1);
      rd(OFS_PERS_PROG, 32'h2, "pers");
      rd(OFS_STATUS, 32'h2, "status");
      acc(OP_ERASE, 3'd1, 1'b0);
      wr(OFS_STATUS, 32'h2);
   endtask
   task automatic t_pwd();
      i_flash_host.cfg_wr(6'h03);
      rd(OFS_STATUS, 32'hc, "status");
      wr(OFS_PERS_PROG, 32'h4);
      rd(OFS_PERS_PROG, 32'h2, "pers");
      acc(OP_READ, 3'd1, 1'b0);
      acc(OP_READ, 3'd7, 1'b1);
      @(posedge hclk) tbs <= 1'b1;
      acc(OP_READ, 3'd0, 1'b1);
      acc(OP_READ, 3'd7, 1'b0);
      acc(OP_PROGRAM, 3'd0, 1'b0);
      wr(OFS_KEY, ~PWD);
      wr(OFS_KEY, PWD);
      rd(OFS_STATUS, 32'h3, "status");
      acc(OP_READ, 3'd1, 1'b1);
   endtask
   task automatic t_power();
      @(posedge hclk);
      hresetn    <= 1'b0;
      power_on_n <= 1'b0;
      @(posedge hclk);
      hresetn    <= 1'b1;
      power_on_n <= 1'b1;
      rd(OFS_CFG, 32'hffff, "cfg");
      rd(OFS_PERS_PROG, 32'h0, "pers");
      rd(OFS_DYN_SET, 32'h0, "dyn");
   endtask
   // Main sequence; both resets held together for a clean power-up
   initial begin
      {hresetn, power_on_n, tbs, access_valid, access_sector} = '0;
      access_op = OP_NONE;
      repeat (5) @(posedge hclk);
      hresetn    <= 1'b1;
      power_on_n <= 1'b1;
      t_reset();
      t_dyn();
      t_otp();
      t_pwd();
      t_power();
      results();
   end
endmodule
